/* File: logic/mrrd_defines.svh */
// constants for the mode register read responder
`ifndef MRRD_DEFINES_SVH
`define MRRD_DEFINES_SVH
`define MRRD_CLK_HZ 50000000
`define MRRD_DQ_W 32
`define MRRD_RL 8'h08
`define MRRD_BEATS 3'h4
`define MRRD_TMRR 3'h2
`define MRRD_TSI_MS 32
`define MRRD_TSI_CYC (`MRRD_TSI_MS * (`MRRD_CLK_HZ / 1000))
`define MRRD_MA_TEMP 8'h04
`define MRRD_MA_CAL_A 8'h20
`define MRRD_MA_CAL_B 8'h28
`define MRRD_PAT_A 4'h5
`define MRRD_PAT_B 4'hC
`define MRRD_TEMP_HOT 3'h3
`define MRRD_TEMP_RST 3'h0
`define MRRD_CMD_MRR 4'h8
`define MRRD_CMD_NOP 4'hF
`endif

/* File: logic/mrrd_pkg.sv */
// types for the mode register read responder
package mrrd_pkg;
   // command as seen on the ca bus at a rising edge
   typedef struct packed {
      logic cs_n;
      logic [3:0] op;
      logic [7:0] ma;
   } mrrd_cmd_s;
   // read burst state
   typedef enum logic [2:0] {
      MRRD_IDLE = 3'b001,
      MRRD_WAIT = 3'b010,
      MRRD_BURST = 3'b100
   } mrrd_state_e;
endpackage : mrrd_pkg

/* File: logic/mrrd_temp_reg.sv */
// temperature status register with periodic sensor sampling
`timescale 1ns/100ps
`include "mrrd_defines.svh"
module mrrd_temp_reg #(
   parameter int unsigned TSI_CYC = `MRRD_TSI_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // sensor side
   input wire logic [2:0] sensor_code,
   input wire logic wake,
   // status out
   output logic [2:0] temp_q
);
   logic [31:0] cnt_q;
   logic tick;
   assign tick = (cnt_q >= TSI_CYC - 1);
   // sample at least every update interval, and at once on wake
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cnt_q <= 32'h0;
         temp_q <= `MRRD_TEMP_RST;
      end else if (tick || wake) begin
         cnt_q <= 32'h0;
         temp_q <= sensor_code;
      end else begin
         cnt_q <= cnt_q + 32'h1;
      end
   end
endmodule : mrrd_temp_reg

/* File: logic/mrrd_core.sv */
// mode register read responder: status, calibration patterns, burst out
// Summary of operation
// - every read is four beats, uninterrupted
// - temperature status readable at register four
// - temperature status refreshed within 32 ms
// - status fresh after low power exit
// - code 011b means case may exceed 85C
// - register 32 returns 1,0,1,0
// - register 40 returns 0,0,1,1
// - calibration drives dq0 every beat
// - pattern on dq0, dq8, plus dq16, dq24 when wide32
// - other enabled lanes copy dq0
// - ordinary register in first beat, lanes 7:0
// - command period two cycles
`timescale 1ns/100ps
`include "mrrd_defines.svh"
module mrrd_core #(
   parameter int unsigned TSI_CYC = `MRRD_TSI_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // command bus, decoded per edge
   input wire mrrd_pkg::mrrd_cmd_s cmd,
   // generic register contents for other addresses
   input wire logic [7:0] reg_rdata,
   // temperature sensor, low power exit and width select
   input wire logic [2:0] sensor_code,
   input wire logic lp_exit,
   input wire logic wide32,
   // data out
   output logic [`MRRD_DQ_W-1:0] dq_o,
   output logic [`MRRD_DQ_W-1:0] dq_oe,
   output logic dqs_o,
   output logic hot_flag_q,
   output logic cmd_err_q
);
   ////////////////////////////////////////////////////////////////////
   // decode
   // read sequencer state, one-hot
   mrrd_pkg::mrrd_state_e st_q, st_d;
   // latency countdown from the command edge towards the first beat
   logic [7:0] lat_q, lat_d;
   // beat index within the burst
   logic [2:0] beat_q, beat_d;
   // command period countdown, non-nop is illegal while nonzero
   logic [2:0] tmrr_q, tmrr_d;
   // register address captured with the accepted command
   logic [7:0] ma_q, ma_d;
   // current temperature status from the sampler
   logic [2:0] temp;
   // command decode strobes
   logic is_mrr, is_nop, start;
   // mrr: cs low and ca3..0 = 1000
   assign is_mrr = !cmd.cs_n && cmd.op == `MRRD_CMD_MRR;
   // deselect or explicit nop code both count as nop
   assign is_nop = cmd.cs_n || cmd.op == `MRRD_CMD_NOP;
   // no new read while one is in flight
   assign start = is_mrr && st_q == mrrd_pkg::MRRD_IDLE;
   // status sampler: periodic refresh plus resample on low power exit
   mrrd_temp_reg #(.TSI_CYC(TSI_CYC)) u_temp (
      .clk(clk),
      .nrst(nrst),
      .sensor_code(sensor_code),
      .wake(lp_exit),
      .temp_q(temp)
   );
   ////////////////////////////////////////////////////////////////////
   // beat data
   // pattern bit for a beat; bit n of the pattern goes out in beat n
   function automatic logic pat_bit(input logic [3:0] p,
                                    input logic [2:0] b);
      pat_bit = p[b[1:0]];
   endfunction : pat_bit
   // address match strobes for the two calibration registers
   logic is_cal_a, is_cal_b, is_cal;
   // calibration bit of the current beat, copied to every lane
   logic lane_bit;
   // byte returned on lanes 7:0 for ordinary registers
   logic [7:0] byte_val;
   // full data word of the current beat before lane masking
   logic [`MRRD_DQ_W-1:0] word;
   assign is_cal_a = ma_q == `MRRD_MA_CAL_A;
   assign is_cal_b = ma_q == `MRRD_MA_CAL_B;
   assign is_cal = is_cal_a || is_cal_b;
   // only used while is_cal; pattern b is the fallback select
   assign lane_bit = is_cal_a ? pat_bit(`MRRD_PAT_A, beat_q)
                              : pat_bit(`MRRD_PAT_B, beat_q);
   // status register or the generic contents supplied from outside
   assign byte_val = (ma_q == `MRRD_MA_TEMP) ? {5'h00, temp}
                                             : reg_rdata;
   // calibration replicates on all lanes; else first beat low byte;
   // lanes with undefined content are driven low so they never float
   assign word = is_cal ? {`MRRD_DQ_W{lane_bit}}
               : (beat_q == 3'h0) ? {24'h000000, byte_val}
               : 32'h00000000;
   ////////////////////////////////////////////////////////////////////
   // state
   // idle, then wait out the read latency, then four beats, then idle
   always_comb begin
      st_d = st_q;
      case (st_q)
         // a read is accepted only from idle
         mrrd_pkg::MRRD_IDLE: if (start) st_d = mrrd_pkg::MRRD_WAIT;
         // move on the edge where the latency count steps from one to zero
         mrrd_pkg::MRRD_WAIT: if (lat_q == 8'h01)
            st_d = mrrd_pkg::MRRD_BURST;
         // the burst always runs its full four beats
         mrrd_pkg::MRRD_BURST: if (beat_q == `MRRD_BEATS - 3'h1)
            st_d = mrrd_pkg::MRRD_IDLE;
         // unknown code: recover to idle
         default: st_d = mrrd_pkg::MRRD_IDLE;
      endcase
   end
   ////////////////////////////////////////////////////////////////////
   // counters and captured address
   // latency load on accept, else count down to zero and hold there
   assign lat_d = start ? `MRRD_RL
                : (lat_q != 8'h00) ? lat_q - 8'h01 : lat_q;
   // command period: the accept edge itself is its first cycle
   assign tmrr_d = start ? `MRRD_TMRR - 3'h1
                 : (tmrr_q != 3'h0) ? tmrr_q - 3'h1 : tmrr_q;
   // address is held for the whole read
   assign ma_d = start ? cmd.ma : ma_q;
   // beat index runs only in the burst state
   assign beat_d = (st_q == mrrd_pkg::MRRD_BURST) ? beat_q + 3'h1
                 : 3'h0;
   // sequencer state register
   always_ff @(posedge clk) begin
      if (!nrst) begin
         st_q <= mrrd_pkg::MRRD_IDLE;
      end else begin
         st_q <= st_d;
      end
   end
   // read latency countdown
   always_ff @(posedge clk) begin
      if (!nrst) begin
         lat_q <= 8'h00;
      end else begin
         lat_q <= lat_d;
      end
   end
   // command period countdown
   always_ff @(posedge clk) begin
      if (!nrst) begin
         tmrr_q <= 3'h0;
      end else begin
         tmrr_q <= tmrr_d;
      end
   end
   // captured register address
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ma_q <= 8'h00;
      end else begin
         ma_q <= ma_d;
      end
   end
   // beat index
   always_ff @(posedge clk) begin
      if (!nrst) begin
         beat_q <= 3'h0;
      end else begin
         beat_q <= beat_d;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // outputs, all registered
   // high while a beat is being launched
   logic burst_d;
   // lanes that the selected width drives
   logic [`MRRD_DQ_W-1:0] lane_mask;
   // next values of the data pins and their enables
   logic [`MRRD_DQ_W-1:0] dq_d, dq_oe_d;
   // next strobe, status flag and error flag
   logic dqs_d, hot_d, err_d;
   assign burst_d = st_q == mrrd_pkg::MRRD_BURST;
   // x16 uses the low two bytes only
   assign lane_mask = wide32 ? 32'hFFFFFFFF : 32'h0000FFFF;
   // pins rest low with enables off outside the burst
   assign dq_d = burst_d ? (word & lane_mask) : 32'h00000000;
   assign dq_oe_d = burst_d ? lane_mask : 32'h00000000;
   // strobe high on even beats, so it toggles over the whole burst
   assign dqs_d = burst_d ? !beat_q[0] : 1'b0;
   // status code that warns the case may already be too hot
   assign hot_d = temp == `MRRD_TEMP_HOT;
   // sticky flag: non-nop during command period or busy read;
   // only reset clears it, so a host fault is never lost
   assign err_d = cmd_err_q || (tmrr_q != 3'h0 && !is_nop)
                  || (is_mrr && !start);
   // data pins and their enables
   always_ff @(posedge clk) begin
      if (!nrst) begin
         dq_o <= 32'h00000000;
         dq_oe <= 32'h00000000;
      end else begin
         dq_o <= dq_d;
         dq_oe <= dq_oe_d;
      end
   end
   // data strobe
   always_ff @(posedge clk) begin
      if (!nrst) begin
         dqs_o <= 1'b0;
      end else begin
         dqs_o <= dqs_d;
      end
   end
   // temperature warning flag
   always_ff @(posedge clk) begin
      if (!nrst) begin
         hot_flag_q <= 1'b0;
      end else begin
         hot_flag_q <= hot_d;
      end
   end
   // command error flag
   always_ff @(posedge clk) begin
      if (!nrst) begin
         cmd_err_q <= 1'b0;
      end else begin
         cmd_err_q <= err_d;
      end
   end
endmodule : mrrd_core

/* File: bench/mrrd_checker.sv */
// port assertions for the read responder
`timescale 1ns/100ps
`include "mrrd_defines.svh"
module mrrd_checker (
   // clock, reset, inputs
   input wire logic clk,
   input wire logic nrst,
   input wire mrrd_pkg::mrrd_cmd_s cmd,
   input wire logic wide32,
   // outputs
   input wire logic [31:0] dq_o,
   input wire logic [31:0] dq_oe,
   input wire logic dqs_o,
   input wire logic cmd_err_q
);
   logic [3:0] cnt_q; // busy countdown, zero on the first free edge
   wire mrr = !cmd.cs_n && cmd.op == `MRRD_CMD_MRR;
   wire nn = !cmd.cs_n && cmd.op != 4'hF;
   wire go = mrr && cnt_q == 4'h0;
   // model of the busy window
   always_ff @(posedge clk)
      if (!nrst) cnt_q <= 4'h0;
      else if (go) cnt_q <= 4'hC;
      else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_on; $rose(dq_oe[0]); endsequence
   sequence s_tog; dqs_o ##1 !dqs_o ##1 dqs_o ##1 !dqs_o; endsequence
   property p_len; s_on |-> dq_oe[0] [*4] ##1 !dq_oe[0]; endproperty
   property p_dqs; s_on |-> s_tog; endproperty
   property p_lat; go |-> ##9 !dq_oe[0] ##1 dq_oe[0]; endproperty
   sequence s_pat_a; dq_o[0] ##1 !dq_o[0] ##1 dq_o[0] ##1 !dq_o[0];
   endsequence
   sequence s_pat_b; !dq_o[0] ##1 !dq_o[0] ##1 dq_o[0] ##1 dq_o[0];
   endsequence
   property p_pa; go && cmd.ma == `MRRD_MA_CAL_A |-> ##10 s_pat_a;
   endproperty
   property p_pb; go && cmd.ma == `MRRD_MA_CAL_B |-> ##10 s_pat_b;
   endproperty
   property p_mr4; go && cmd.ma == `MRRD_MA_TEMP |->
      ##10 dq_o[31:3] == 29'h0; endproperty
   property p_x16; !wide32 && dq_oe[0] |-> dq_oe[31:16] == 16'h0;
   endproperty
   property p_err; nn && cnt_q == 4'hC |=> cmd_err_q; endproperty
   property p_busy; mrr && cnt_q != 4'h0 |=> cmd_err_q; endproperty
   a_len: assert property (p_len) else $error("burst length");
   a_dqs: assert property (p_dqs) else $error("strobe");
   a_lat: assert property (p_lat) else $error("latency");
   a_pa: assert property (p_pa) else $error("pattern a");
   a_pb: assert property (p_pb) else $error("pattern b");
   a_mr4: assert property (p_mr4) else $error("status");
   a_x16: assert property (p_x16) else $error("x16 lanes");
   a_err: assert property (p_err) else $error("nop window");
   a_busy: assert property (p_busy) else $error("busy read");
endmodule : mrrd_checker
bind mrrd_core mrrd_checker i_chk (.clk(clk), .nrst(nrst), .cmd(cmd),
   .wide32(wide32), .dq_o(dq_o), .dq_oe(dq_oe), .dqs_o(dqs_o),
   .cmd_err_q(cmd_err_q));

/* File: bench/mrrd_host.sv */
// host model issuing mode register reads
`timescale 1ns/100ps
`include "mrrd_defines.svh"
module mrrd_host (
   // clock and requests
   input wire logic clk,
   input wire logic go,
   input wire logic bad,
   input wire logic [7:0] ma,
   // command bus
   output mrrd_pkg::mrrd_cmd_s cmd
);
   logic bad_q = 1'b0; // illegal second read pending
   initial cmd = '{1'b1, 4'hF, 8'h00};
   // reads only, from idle except the illegal second read that bad adds
   always @(negedge clk) begin
      if (go || bad_q) cmd <= '{1'b0, `MRRD_CMD_MRR, ma};
      else cmd <= '{1'b1, 4'hF, ~ma};
      bad_q <= go && bad;
   end
endmodule : mrrd_host

/* File: bench/mrrd_tb.sv */
// self-checking bench for the read responder
`timescale 1ns/100ps
`include "mrrd_defines.svh"
module testbench;
   logic clk = 1'b0, nrst = 1'b0, go = 1'b0, bad = 1'b0, lp_exit = 1'b0;
   logic wide32 = 1'b1;
   logic [7:0] ma = 8'h00, reg_rdata = 8'h00;
   logic [2:0] sensor_code = 3'h0;
   logic [31:0] rnd = 32'h64B33B16;
   int mismatches = 0, n_tests = 0, cyc = 0;
   logic [63:0] exp_q[$]; // enables and data per beat
   mrrd_pkg::mrrd_cmd_s cmd;
   wire [31:0] dq_o, dq_oe;
   wire dqs_o, hot_flag_q, cmd_err_q;
   always #10 clk = ~clk;
   mrrd_host i_host (.clk(clk), .go(go), .bad(bad), .ma(ma), .cmd(cmd));
   mrrd_core #(.TSI_CYC(100)) i_dut (.clk(clk), .nrst(nrst), .cmd(cmd),
      .reg_rdata(reg_rdata), .sensor_code(sensor_code), .lp_exit(lp_exit),
      .wide32(wide32), .dq_o(dq_o), .dq_oe(dq_oe), .dqs_o(dqs_o),
      .hot_flag_q(hot_flag_q), .cmd_err_q(cmd_err_q));
   task automatic check(input logic [63:0] got, input logic [63:0] want);
      n_tests++;
      if (got !== want) begin
         mismatches++;
         $display("mismatch %0t %h %h", $time, got, want);
      end
   endtask : check
   task automatic wrap_up;
      if (mismatches == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : wrap_up
   // next value of the xorshift sequence
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xorshift = t ^ (t << 5);
   endfunction : xorshift
   // one read, four beats noted
   task automatic rd(input logic [7:0] a, input logic [3:0] p,
                     input logic cal, input logic [7:0] b);
      logic [31:0] m;
      m = wide32 ? 32'hFFFFFFFF : 32'h0000FFFF;
      for (int i = 0; i < 4; i++)
         exp_q.push_back({m, cal ? (p[i] ? m : 32'h0) :
                          (i == 0 ? {24'h0, b} : 32'h0)});
      ma <= a;
      go <= 1'b1;
      @(negedge clk) go <= 1'b0;
      repeat (17) @(negedge clk);
   endtask : rd
   // beat monitor and hang limit
   always @(negedge clk) begin
      cyc++;
      if (cyc > 2000) begin
         mismatches++;
         wrap_up();
      end else if (dq_oe !== 32'h0) begin
         check({dq_oe, dq_o}, exp_q.pop_front());
      end
   end
   initial begin
      repeat (16) @(negedge clk);
      nrst <= 1'b1;
      for (int w = 0; w < 2; w++) begin
         wide32 = !w[0];
         rd(`MRRD_MA_CAL_A, `MRRD_PAT_A, 1'b1, 8'h00);
         rd(`MRRD_MA_CAL_B, `MRRD_PAT_B, 1'b1, 8'h00);
         rnd = xorshift(rnd);
         reg_rdata = rnd[7:0];
         rd({2'h1, rnd[13:8]}, 4'h0, 1'b0, rnd[7:0]);
         check({63'h0, cmd_err_q}, 64'h0);
      end
      sensor_code = `MRRD_TEMP_HOT;
      lp_exit = 1'b1;
      @(negedge clk) lp_exit = 1'b0;
      repeat (2) @(negedge clk);
      check({63'h0, hot_flag_q}, 64'h1);
      rd(`MRRD_MA_TEMP, 4'h0, 1'b0, 8'h03);
      sensor_code = 3'h5;
      repeat (110) @(negedge clk);
      check({63'h0, hot_flag_q}, 64'h0);
      rd(`MRRD_MA_TEMP, 4'h0, 1'b0, 8'h05);
      bad <= 1'b1;
      rd(`MRRD_MA_CAL_A, `MRRD_PAT_A, 1'b1, 8'h00);
      check({63'h0, cmd_err_q}, 64'h1);
      check(64'(exp_q.size()), 64'h0);
      wrap_up();
   end
endmodule : testbench
